//--- logic/cafim_core.sv
// top of the block: configuration lock, receive buffering, flags,
// interrupt requests and low-power mode selection.
// assumes the protocol engine delivers frame bytes, frame-ok pulses and error counts
// synchronous to core_clk; the host drives flag clears as write-one pulses.
`timescale 1ns/1ps
module cafim_core
    import cafim_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    // mode inputs
    input wire logic cpu_stop,
    input wire logic sleep_ack,
    input wire logic soft_reset_lock,
    // configuration writes
    input wire logic cfg_wr_en,
    input wire logic [3:0] cfg_sel,
    input wire logic [7:0] cfg_wdata,
    // interrupt enables
    input wire logic wake_irq_enable,
    input wire logic rx_warn_irq_enable,
    input wire logic tx_warn_irq_enable,
    input wire logic rx_passive_irq_enable,
    input wire logic tx_passive_irq_enable,
    input wire logic bus_off_irq_enable,
    input wire logic overrun_irq_enable,
    input wire logic rx_full_irq_enable,
    input wire logic tx_buf0_empty_irq_enable,
    input wire logic tx_buf1_empty_irq_enable,
    input wire logic tx_buf2_empty_irq_enable,
    // host flag clears, write one to clear
    input wire logic rx_flag_clr_wr,
    input wire logic [7:0] rx_flag_clr_mask,
    input wire logic tx_flag_clr_wr,
    input wire logic [2:0] tx_flag_clr_mask,
    // protocol engine side
    input wire logic rx_byte_valid,
    input wire logic [3:0] rx_byte_idx,
    input wire logic [7:0] rx_byte_data,
    input wire logic rx_frame_ok,
    input wire logic rx_own_frame,
    input wire logic [2:0] tx_done,
    input wire logic [8:0] rx_err_cnt,
    input wire logic [8:0] tx_err_cnt,
    input wire logic bus_activity,
    input wire logic proto_tx_bit,
    // host read of the foreground buffer
    input wire logic [3:0] fg_rd_idx,
    output logic [7:0] fg_rd_data,
    // register views
    output logic [7:0] module_ctrl1_reg,
    output logic [7:0] bit_timing0_reg,
    output logic [7:0] bit_timing1_reg,
    output logic [7:0] filter_mode_ctrl_reg,
    output logic [31:0] id_accept_pattern_regs,
    output logic [31:0] id_dont_care_regs,
    output logic [7:0] rx_flag_reg,
    output logic [2:0] tx_flag_reg,
    output cafim_err_t err_state_r,
    output cafim_mode_t mode_r,
    // requests, clock gates and bus pin
    output logic irq_wake_r,
    output logic irq_err_r,
    output logic irq_rx_r,
    output logic irq_tx_r,
    output logic core_clk_en_r,
    output logic reg_clk_en_r,
    output logic bus_tx_out_r
);
    logic [1:0] fmode_r;
    logic [1:0] hit_idx_r;
    logic [31:0] id_cap_r;
    logic bg_bank_r;
    logic bg_full_r;
    logic [1:0] pend_idx_r;
    logic [7:0] rflag_r;
    logic [7:0] rflag_nxt;
    logic [2:0] txe_r;
    logic [2:0] txe_nxt;
    logic [7:0] rset;
    logic [7:0] rcond;
    logic [7:0] rclr;
    logic filt_hit;
    logic [1:0] filt_idx;
    logic run;
    logic accept_evt;
    logic copy_now;
    logic bg_we;
    logic [2:0] txe_en;
    cafim_mode_t mode_nxt;

    assign run = (mode_r == CAFIM_NORMAL);
    assign filter_mode_ctrl_reg = {2'h0, fmode_r, 2'h0, hit_idx_r};
    assign rx_flag_reg = rflag_r;
    assign tx_flag_reg = txe_r;
    assign txe_en = {tx_buf2_empty_irq_enable, tx_buf1_empty_irq_enable,
                     tx_buf0_empty_irq_enable};

    // mode selection; both bits set falls to soft reset as the safer choice
    always_comb begin
        if (cpu_stop) begin
            mode_nxt = CAFIM_POWER_DOWN;
        end else if (soft_reset_lock) begin
            mode_nxt = CAFIM_SOFT_RESET;
        end else if (sleep_ack) begin
            mode_nxt = CAFIM_SLEEP;
        end else begin
            mode_nxt = CAFIM_NORMAL;
        end
    end

    // mode register and derived clock gates
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= CAFIM_NORMAL;
            core_clk_en_r <= 1'h0;
            reg_clk_en_r <= 1'h0;
        end else begin
            mode_r <= mode_nxt;
            // protocol clock only in normal, register clock off in power-down
            core_clk_en_r <= (mode_nxt == CAFIM_NORMAL);
            reg_clk_en_r <= (mode_nxt != CAFIM_POWER_DOWN);
        end
    end

    // bus pin held recessive in every low-power mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_tx_out_r <= RECESSIVE;
        end else begin
            bus_tx_out_r <= (mode_nxt == CAFIM_NORMAL) ? proto_tx_bit : RECESSIVE;
        end
    end

    // configuration accepted only while soft reset is set
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            module_ctrl1_reg <= CFG_RESET;
            bit_timing0_reg <= CFG_RESET;
            bit_timing1_reg <= CFG_RESET;
            fmode_r <= FM_SINGLE;
            id_accept_pattern_regs <= 32'h0000_0000;
            id_dont_care_regs <= 32'h0000_0000;
        end else if (cfg_wr_en && soft_reset_lock) begin
            case (cfg_sel)
                SEL_CTRL1: module_ctrl1_reg <= cfg_wdata;
                SEL_BT0: bit_timing0_reg <= cfg_wdata;
                SEL_BT1: bit_timing1_reg <= cfg_wdata;
                SEL_FMODE: fmode_r <= cfg_wdata[5:4];
                SEL_ACC0: id_accept_pattern_regs[31:24] <= cfg_wdata;
                SEL_ACC0 + 4'h1: id_accept_pattern_regs[23:16] <= cfg_wdata;
                SEL_ACC0 + 4'h2: id_accept_pattern_regs[15:8] <= cfg_wdata;
                SEL_ACC0 + 4'h3: id_accept_pattern_regs[7:0] <= cfg_wdata;
                SEL_MSK0: id_dont_care_regs[31:24] <= cfg_wdata;
                SEL_MSK0 + 4'h1: id_dont_care_regs[23:16] <= cfg_wdata;
                SEL_MSK0 + 4'h2: id_dont_care_regs[15:8] <= cfg_wdata;
                SEL_MSK0 + 4'h3: id_dont_care_regs[7:0] <= cfg_wdata;
                default: fmode_r <= fmode_r; // unused selects are ignored
            endcase
        end
    end

    // background writes are held off while it keeps a pending message,
    // so the pending one survives and the newcomer is the one lost
    assign bg_we = run && rx_byte_valid && !bg_full_r && (rx_byte_idx < BUF_BYTES);

    // identifier bytes captured even while the background bank is held, so a
    // frame landing on top of a pending one is filtered on its own identifier
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            id_cap_r <= 32'h0000_0000;
        end else if (run && rx_byte_valid && (rx_byte_idx < ID_BYTES)) begin
            id_cap_r[(5'h18 - {rx_byte_idx[1:0], 3'h0}) +: 8] <= rx_byte_data;
        end
    end

    cafim_filter u_filter (
        .mode(fmode_r),
        .id_bits(id_cap_r),
        .pattern(id_accept_pattern_regs),
        .dont_care(id_dont_care_regs),
        .hit(filt_hit),
        .hit_idx(filt_idx)
    );

    cafim_rxmem u_rxmem (
        .core_clk(core_clk),
        .we(bg_we),
        .waddr({bg_bank_r, rx_byte_idx}),
        .wdata(rx_byte_data),
        .raddr({~bg_bank_r, fg_rd_idx}),
        .rdata_r(fg_rd_data)
    );

    // own frames are not accepted; loopback is the engine's business
    assign accept_evt = run && rx_frame_ok && !rx_own_frame && filt_hit;
    // hand-over only while the foreground is free and the core runs
    assign copy_now = run && !rflag_r[RF_RXF] && (bg_full_r || (accept_evt && !bg_full_r));

    // ping-pong swap stands in for the byte copy
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bg_bank_r <= 1'h0;
            bg_full_r <= 1'h0;
            pend_idx_r <= 2'h0;
            hit_idx_r <= 2'h0;
        end else if (copy_now) begin
            bg_bank_r <= ~bg_bank_r;
            bg_full_r <= 1'h0;
            // hit index follows the message into the foreground
            hit_idx_r <= bg_full_r ? pend_idx_r : filt_idx;
        end else if (accept_evt && !bg_full_r) begin
            bg_full_r <= 1'h1;
            pend_idx_r <= filt_idx;
        end
    end

    // persisting conditions from the read-only error counters
    always_comb begin
        rcond = 8'h00;
        rcond[RF_RWRN] = (rx_err_cnt >= WARN_LIMIT);
        rcond[RF_TWRN] = (tx_err_cnt >= WARN_LIMIT);
        rcond[RF_RPAS] = (rx_err_cnt > PASSIVE_LIMIT);
        rcond[RF_TPAS] = (tx_err_cnt > PASSIVE_LIMIT);
        rcond[RF_BOFF] = (tx_err_cnt > BUSOFF_LIMIT);
    end

    // event sources of the receive flag register
    always_comb begin
        rset = rcond;
        // wake only with sleep ack and enable both set
        rset[RF_WAKE] = bus_activity && sleep_ack && wake_irq_enable
                        && (mode_r == CAFIM_SLEEP || mode_r == CAFIM_POWER_DOWN);
        // accepted frame with both buffers occupied is dropped
        rset[RF_OVR] = accept_evt && bg_full_r && rflag_r[RF_RXF];
        // full flag right after the accepted frame ends
        rset[RF_RXF] = copy_now;
    end

    // write-one clear, refused while the cause persists; set beats clear
    assign rclr = (rx_flag_clr_wr ? rx_flag_clr_mask : 8'h00) & ~rcond;
    assign rflag_nxt = rset | (rflag_r & ~rclr);
    assign txe_nxt = tx_done | (txe_r & ~(tx_flag_clr_wr ? tx_flag_clr_mask : 3'h0));

    // error flags derive from the counters; no path writes the counters
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rflag_r <= 8'h00;
            txe_r <= TXE_RESET;
        end else begin
            rflag_r <= rflag_nxt;
            txe_r <= txe_nxt;
        end
    end

    // fault confinement state follows the counters
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_state_r <= CAFIM_ERR_ACTIVE;
        end else if (rcond[RF_BOFF]) begin
            err_state_r <= CAFIM_BUS_OFF;
        end else if (rcond[RF_RPAS] || rcond[RF_TPAS]) begin
            err_state_r <= CAFIM_ERR_PASSIVE;
        end else begin
            err_state_r <= CAFIM_ERR_ACTIVE;
        end
    end

    // eleven sources onto four requests, held while any enabled flag stands
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_wake_r <= 1'h0;
            irq_err_r <= 1'h0;
            irq_rx_r <= 1'h0;
            irq_tx_r <= 1'h0;
        end else begin
            irq_wake_r <= rflag_nxt[RF_WAKE] && wake_irq_enable;
            irq_err_r <= (rflag_nxt[RF_RWRN] && rx_warn_irq_enable)
                      || (rflag_nxt[RF_TWRN] && tx_warn_irq_enable)
                      || (rflag_nxt[RF_RPAS] && rx_passive_irq_enable)
                      || (rflag_nxt[RF_TPAS] && tx_passive_irq_enable)
                      || (rflag_nxt[RF_BOFF] && bus_off_irq_enable)
                      || (rflag_nxt[RF_OVR] && overrun_irq_enable);
            irq_rx_r <= rflag_nxt[RF_RXF] && rx_full_irq_enable;
            irq_tx_r <= |(txe_nxt & txe_en);
        end
    end

    chk_pin_recessive: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (mode_r != CAFIM_NORMAL) |-> (bus_tx_out_r == RECESSIVE))
        else $error("bus pin not recessive in low-power mode");

    chk_cfg_lock: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (cfg_wr_en && !soft_reset_lock) |=> ($stable(id_accept_pattern_regs)
            && $stable(id_dont_care_regs) && $stable(fmode_r)))
        else $error("configuration changed while unlocked");

    // closed filter never raises the full flag while no message is pending in background
    chk_closed_mode: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (fmode_r == FM_CLOSED && !bg_full_r && !rflag_r[RF_RXF]) |=> !rflag_r[RF_RXF])
        else $error("full flag set in closed filter mode");

    // warning flag held while counter at limit
    chk_warn_hold: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (rx_err_cnt >= WARN_LIMIT) [*2] |-> rflag_r[RF_RWRN])
        else $error("receive warning flag missing");

    chk_bus_off: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (tx_err_cnt > BUSOFF_LIMIT) |=> (rflag_r[RF_BOFF] && err_state_r == CAFIM_BUS_OFF))
        else $error("bus-off not entered");

    // overrun when both buffers already hold messages
    chk_overrun: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (accept_evt && bg_full_r && rflag_r[RF_RXF]) |=> (rflag_r[RF_OVR] && $stable(bg_bank_r)))
        else $error("overrun not flagged or buffer moved");

    // wake flag rises only under ack and enable
    chk_wake_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $rose(rflag_r[RF_WAKE]) |-> ($past(sleep_ack) && $past(wake_irq_enable)))
        else $error("wake flag without ack and enable");

    // no swap while the foreground is full
    chk_copy_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (rflag_r[RF_RXF] && !(rx_flag_clr_wr && rx_flag_clr_mask[RF_RXF])) |=> $stable(bg_bank_r))
        else $error("foreground overwritten while full");

    // receive request follows its flag and enable
    chk_rx_request: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (rflag_r[RF_RXF] && $past(rx_full_irq_enable)) |-> irq_rx_r)
        else $error("receive request dropped while flag set");
endmodule // cafim_core

//--- logic/cafim_filter.sv
// maskable identifier compare in four layouts; purely combinational.
// assumes identifier bytes in the same order as the pattern bytes.
`timescale 1ns/1ps
module cafim_filter
    import cafim_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic [31:0] id_bits,
    input wire logic [31:0] pattern,
    input wire logic [31:0] dont_care,
    output logic hit,
    output logic [1:0] hit_idx
);
    function automatic logic match8(input logic [7:0] id, input logic [7:0] pat,
                                    input logic [7:0] dc);
        match8 = &(~(id ^ pat) | dc);
    endfunction

    logic [3:0] hits;

    always_comb begin
        hits = 4'h0;
        case (mode)
            FM_SINGLE: hits[0] = match8(id_bits[31:24], pattern[31:24], dont_care[31:24])
                               & match8(id_bits[23:16], pattern[23:16], dont_care[23:16])
                               & match8(id_bits[15:8], pattern[15:8], dont_care[15:8])
                               & match8(id_bits[7:0], pattern[7:0], dont_care[7:0]);
            // two half-width filters on the upper identifier bytes
            FM_DUAL: begin
                hits[0] = match8(id_bits[31:24], pattern[31:24], dont_care[31:24])
                        & match8(id_bits[23:16], pattern[23:16], dont_care[23:16]);
                hits[1] = match8(id_bits[31:24], pattern[15:8], dont_care[15:8])
                        & match8(id_bits[23:16], pattern[7:0], dont_care[7:0]);
            end
            // four byte filters on the first identifier byte
            FM_QUAD: begin
                hits[0] = match8(id_bits[31:24], pattern[31:24], dont_care[31:24]);
                hits[1] = match8(id_bits[31:24], pattern[23:16], dont_care[23:16]);
                hits[2] = match8(id_bits[31:24], pattern[15:8], dont_care[15:8]);
                hits[3] = match8(id_bits[31:24], pattern[7:0], dont_care[7:0]);
            end
            default: hits = 4'h0;
        endcase
    end

    always_comb begin
        hit = |hits;
        if (hits[0]) begin
            hit_idx = 2'h0;
        end else if (hits[1]) begin
            hit_idx = 2'h1;
        end else if (hits[2]) begin
            hit_idx = 2'h2;
        end else begin
            hit_idx = 2'h3;
        end
    end
endmodule // cafim_filter

//--- logic/cafim_pkg.sv
// constants, field positions and mode types for the acceptance filter,
// flag, interrupt and low-power mode block.
// assumes a protocol engine beside it that supplies frame events and error counts.
//
// Summary of operation
// - compare received identifier bits with pattern, skipping bits masked don't care
// - hit sets receive full flag and two-bit hit index; lowest filter wins
// - single mode: one 32-bit filter over whole identifier and control bits
// - dual mode: two independent 16-bit filters over upper identifier bits
// - quad mode: four independent 8-bit filters over first identifier byte
// - closed mode accepts no frame; a message already pending in background still moves to foreground and sets receive full flag
// - eleven maskable sources combine into wake, error, receive, transmit requests
// - transmit request while any enabled transmit buffer empty flag is set
// - receive full and receive request right after end of accepted frame
// - wake request on bus activity in sleep only with ack and enable set
// - warning flags set when receive or transmit error count reaches 96
// - passive flags and passive state when a count exceeds 127
// - bus-off flag and state when transmit count exceeds 255
// - accepted frame with both buffers full is dropped and sets overrun
// - background copied to foreground only while receive full flag is clear
// - each request stays asserted while any enabled flag of it is set
// - host clears a flag by writing one; ignored while its cause persists
// - error counters cannot be written or manipulated by the host
// - configuration and filter registers writable only while soft reset is set
// - transmit output recessive in sleep, soft reset and power-down
// - sleep and soft reset stop core clock; power-down stops all clocks
// - mode chosen from cpu stop, sleep ack and soft reset bits
package cafim_pkg;
    // operating modes of the controller
    typedef enum logic [1:0] {CAFIM_NORMAL, CAFIM_SLEEP, CAFIM_SOFT_RESET, CAFIM_POWER_DOWN}
        cafim_mode_t;
    // fault confinement states
    typedef enum logic [1:0] {CAFIM_ERR_ACTIVE, CAFIM_ERR_PASSIVE, CAFIM_BUS_OFF} cafim_err_t;

    // filter mode encodings held in the filter mode control register
    localparam logic [1:0] FM_SINGLE = 2'h0;
    localparam logic [1:0] FM_DUAL = 2'h1;
    localparam logic [1:0] FM_QUAD = 2'h2;
    localparam logic [1:0] FM_CLOSED = 2'h3;

    // configuration select codes
    localparam logic [3:0] SEL_CTRL1 = 4'h0;
    localparam logic [3:0] SEL_BT0 = 4'h1;
    localparam logic [3:0] SEL_BT1 = 4'h2;
    localparam logic [3:0] SEL_FMODE = 4'h3;
    localparam logic [3:0] SEL_ACC0 = 4'h4;
    localparam logic [3:0] SEL_MSK0 = 4'h8;

    // receive flag register bit positions
    localparam int RF_WAKE = 7;
    localparam int RF_RWRN = 6;
    localparam int RF_TWRN = 5;
    localparam int RF_RPAS = 4;
    localparam int RF_TPAS = 3;
    localparam int RF_BOFF = 2;
    localparam int RF_OVR = 1;
    localparam int RF_RXF = 0;

    // error counter limits
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUSOFF_LIMIT = 9'h0FF;

    // buffer geometry and reset values
    localparam logic [3:0] BUF_BYTES = 4'hD;
    localparam logic [3:0] ID_BYTES = 4'h4;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [2:0] TXE_RESET = 3'h7;
    localparam logic RECESSIVE = 1'h1;
endpackage

//--- logic/cafim_rxmem.sv
// ping-pong receive storage: two banks of sixteen bytes, of which the core writes thirteen.
// assumes one writer (background bank) and one reader (foreground bank).
`timescale 1ns/1ps
module cafim_rxmem
    import cafim_pkg::*;
(
    input wire logic core_clk,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [4:0] raddr,
    output logic [7:0] rdata_r
);
    logic [7:0] mem [0:31];

    // write port, no reset so it maps onto plain storage
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge core_clk) begin
        rdata_r <= mem[raddr];
    end
endmodule // cafim_rxmem

//--- sim/cafim_node.sv
// bus node model: hands received frame bytes and the end-of-frame pulse.
// assumes its outputs are taken on the rising edge of core_clk.
`timescale 1ns/1ps
module cafim_node (
    input wire logic core_clk,
    output logic rx_byte_valid,
    output logic [3:0] rx_byte_idx,
    output logic [7:0] rx_byte_data,
    output logic rx_frame_ok
);
    initial begin
        rx_byte_valid = 1'b0;
        rx_byte_idx = 4'h0;
        rx_byte_data = 8'h00;
        rx_frame_ok = 1'b0;
    end
    // thirteen bytes, identifier msb first, then the end-of-frame pulse
    task automatic send(input logic [31:0] id);
        for (int i = 0; i < 13; i++) begin
            @(negedge core_clk);
            rx_byte_valid = 1'b1;
            rx_byte_idx = i[3:0];
            rx_byte_data = (i < 4) ? id[31-8*i -: 8] : 8'h5A;
        end
        @(negedge core_clk);
        rx_byte_valid = 1'b0;
        // released data line shows the inverse, not a stale byte
        rx_byte_data = ~rx_byte_data;
        rx_frame_ok = 1'b1;
        @(negedge core_clk);
        rx_frame_ok = 1'b0;
    endtask
endmodule // cafim_node

//--- sim/can_acceptance_filter_irq_modes_tb.sv
// bench for the filter, flag, request and mode block.
// assumes cafim_node feeds frames; inputs change on the falling edge.
`timescale 1ns/1ps
module can_acceptance_filter_irq_modes_tb;
    import cafim_pkg::*;
    logic core_clk = 0, arst_n = 0, cpu_stop = 0, slp = 0, lock = 0, cwe = 0;
    logic rcw = 0, tcw = 0, bact = 0, ptx = 0, rbv, rfo, iw, ie, ir, it, cen, ren, btx;
    logic [3:0] sel = 0, rbi;
    logic [7:0] wd = 0, rcm = 0, rbd, c1, fm, rf, fgd, b0, b1;
    logic [31:0] pat, dcr;
    logic [2:0] tcm = 0, txd = 0, tf;
    logic [10:0] en = 11'h7FF;
    logic [8:0] rec = 0, tec = 0;
    cafim_err_t es;
    cafim_mode_t md;
    int err_total = 0, num_checks = 0;
    initial forever #2.5 core_clk = ~core_clk;
    cafim_node p_u (.core_clk(core_clk), .rx_byte_valid(rbv), .rx_byte_idx(rbi),
        .rx_byte_data(rbd), .rx_frame_ok(rfo));
    cafim_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .cpu_stop(cpu_stop),
        .sleep_ack(slp), .soft_reset_lock(lock), .cfg_wr_en(cwe), .cfg_sel(sel),
        .cfg_wdata(wd), .wake_irq_enable(en[0]), .rx_warn_irq_enable(en[1]),
        .tx_warn_irq_enable(en[2]), .rx_passive_irq_enable(en[3]),
        .tx_passive_irq_enable(en[4]), .bus_off_irq_enable(en[5]),
        .overrun_irq_enable(en[6]), .rx_full_irq_enable(en[7]),
        .tx_buf0_empty_irq_enable(en[8]), .tx_buf1_empty_irq_enable(en[9]),
        .tx_buf2_empty_irq_enable(en[10]), .rx_flag_clr_wr(rcw), .rx_flag_clr_mask(rcm),
        .tx_flag_clr_wr(tcw), .tx_flag_clr_mask(tcm), .rx_byte_valid(rbv),
        .rx_byte_idx(rbi), .rx_byte_data(rbd), .rx_frame_ok(rfo), .rx_own_frame(1'b0),
        .tx_done(txd), .rx_err_cnt(rec), .tx_err_cnt(tec), .bus_activity(bact),
        .proto_tx_bit(ptx), .fg_rd_idx(4'h0), .fg_rd_data(fgd), .module_ctrl1_reg(c1),
        .bit_timing0_reg(b0), .bit_timing1_reg(b1), .filter_mode_ctrl_reg(fm),
        .id_accept_pattern_regs(pat), .id_dont_care_regs(dcr), .rx_flag_reg(rf),
        .tx_flag_reg(tf), .err_state_r(es), .mode_r(md), .irq_wake_r(iw),
        .irq_err_r(ie), .irq_rx_r(ir), .irq_tx_r(it), .core_clk_en_r(cen),
        .reg_clk_en_r(ren), .bus_tx_out_r(btx));
    task automatic end_sim();
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // strobes are dropped a cycle before the next request may start
    task automatic cfg(input logic [3:0] s, input logic [7:0] d);
        sel = s;
        wd = d;
        cwe = 1'b1;
        cyc(1);
        cwe = 1'b0;
        cyc(1);
    endtask
    // write-one clears
    // write-one clears only, never a read-modify-write of the flags
    task automatic clr(input logic [7:0] m, input logic [2:0] t);
        rcm = m;
        tcm = t;
        rcw = |m;
        tcw = |t;
        cyc(1);
        rcw = 1'b0;
        tcw = 1'b0;
        cyc(1);
    endtask
    task automatic t_lock();
        cfg(SEL_CTRL1, 8'h3C);
        chk("ctrl1 locked", 8'h00, c1);
        lock = 1'b1;
        cyc(2);
        chk("mode", CAFIM_SOFT_RESET, md);
        chk("pin", 1'b1, btx);
        chk("clk en", 1'b0, cen);
        cfg(SEL_CTRL1, 8'h3C);
        chk("ctrl1 open", 8'h3C, c1);
        cfg(SEL_BT0, 8'h81);
        cfg(SEL_BT1, 8'h7E);
        chk("bt0 open", 8'h81, b0);
        chk("bt1 open", 8'h7E, b1);
    endtask
    task automatic t_filt();
        cfg(SEL_FMODE, 8'h20);
        cfg(SEL_ACC0, 8'h11);
        cfg(SEL_ACC0 + 4'h1, 8'hA5);
        cfg(SEL_ACC0 + 4'h2, 8'hA0);
        cfg(SEL_ACC0 + 4'h3, 8'hA5);
        cfg(SEL_MSK0 + 4'h2, 8'h0F);
        lock = 1'b0;
        cyc(2);
        p_u.send(32'hA512_3456);
        chk("rx full", 1'b1, rf[RF_RXF]);
        chk("hit idx", 2'h1, fm[1:0]);
        chk("irq rx", 1'b1, ir);
        clr(8'h01, 3'h0);
        chk("irq rx off", 1'b0, ir);
        chk("fg byte0", 8'hA5, fgd);
        lock = 1'b1;
        cyc(2);
        cfg(SEL_FMODE, 8'h30);
        lock = 1'b0;
        cyc(2);
        p_u.send(32'hA512_3456);
        chk("closed full", 1'b0, rf[RF_RXF]);
        lock = 1'b1;
        cyc(2);
        cfg(SEL_FMODE, 8'h10);
        cfg(SEL_ACC0, 8'hA5);
        cfg(SEL_ACC0 + 4'h1, 8'h12);
        lock = 1'b0;
        cyc(2);
        p_u.send(32'hA512_3456);
        chk("dual full", 1'b1, rf[RF_RXF]);
        chk("dual idx", 2'h0, fm[1:0]);
        clr(8'h01, 3'h0);
        lock = 1'b1;
        cyc(2);
        cfg(SEL_FMODE, 8'h00);
        cfg(SEL_MSK0 + 4'h2, 8'hFF);
        cfg(SEL_MSK0 + 4'h3, 8'hFF);
        chk("pattern", 32'hA512_A0A5, pat);
        chk("mask", 32'h0000_FFFF, dcr);
        lock = 1'b0;
        cyc(2);
        p_u.send(32'hA512_3456);
        chk("single full", 1'b1, rf[RF_RXF]);
        p_u.send(32'hA512_3456);
        p_u.send(32'hA512_3456);
        chk("overrun", 1'b1, rf[RF_OVR]);
        chk("irq ovr", 1'b1, ie);
        clr(8'h03, 3'h0);
        chk("pend copy", 2'h1, rf[1:0]);
        chk("irq err off", 1'b0, ie);
    endtask
    task automatic t_err();
        rec = 9'h060;
        cyc(2);
        chk("rx warn", 1'b1, rf[RF_RWRN]);
        chk("irq err", 1'b1, ie);
        clr(8'h40, 3'h0);
        chk("warn held", 1'b1, rf[RF_RWRN]);
        tec = 9'h080;
        cyc(2);
        chk("tx pas", 1'b1, rf[RF_TPAS]);
        chk("state pas", CAFIM_ERR_PASSIVE, es);
        tec = 9'h100;
        cyc(2);
        chk("bus off", 1'b1, rf[RF_BOFF]);
        chk("state off", CAFIM_BUS_OFF, es);
    endtask
    task automatic t_tx();
        chk("tx flags", 3'h7, tf);
        chk("irq tx", 1'b1, it);
        clr(8'h00, 3'h7);
        chk("irq tx off", 1'b0, it);
        txd = 3'h2;
        cyc(1);
        txd = 3'h0;
        cyc(1);
        chk("tx buf1", 3'h2, tf);
        chk("irq tx on", 1'b1, it);
    endtask
    task automatic t_mode();
        ptx = 1'b0;
        cyc(2);
        chk("pin normal", 1'b0, btx);
        slp = 1'b1;
        cyc(2);
        chk("sleep", CAFIM_SLEEP, md);
        chk("pin sleep", 1'b1, btx);
        chk("reg clk", 1'b1, ren);
        bact = 1'b1;
        cyc(2);
        chk("irq wake", 1'b1, iw);
        cpu_stop = 1'b1;
        cyc(2);
        chk("pdown", CAFIM_POWER_DOWN, md);
        chk("reg clk off", 1'b0, ren);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_sim();
    end
    initial begin
        cyc(8);
        arst_n = 1'b1;
        cyc(1);
        t_tx();
        t_lock();
        t_filt();
        t_err();
        t_mode();
        end_sim();
    end
endmodule // can_acceptance_filter_irq_modes_tb
